// File: tdm_switch_offset_and_error_regs.sv
// Function
// [RULE_01] offset bits 9..2 hold the binary channel shift of the delayed frame pulse
// [RULE_02] host writes only offsets legal for the rate chosen in bits 1..0
// [RULE_03] output overcapacity flag is high while programmed output channels exceed 4096
// [RULE_04] input overcapacity flag is high while programmed input channels exceed 4096
// [RULE_05] overcapacity flags clear by themselves once programming is within capacity
// [RULE_06] host should disable channels beyond capacity when a flag is raised
// [RULE_07] unused upper bits of the capacity error register read zero
// [RULE_08] each error-flag bit is high exactly when its stream error counter is non-zero
// [RULE_09] flags are recomputed every cycle from current counters and programming
`timescale 1ns/1ns
`include "tdm_regs_params.svh"

module tdm_switch_offset_and_error_regs #(
    parameter int NUM_PULSES = 3,
    parameter int NUM_STREAMS = 16,
    parameter int CHAN_W = 14
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // host register bus
    input wire tdm_regs_pkg::host_req_t i_host_req,
    output tdm_regs_pkg::host_rsp_t o_host_rsp,
    // switch status inputs
    input wire logic [CHAN_W:0] i_input_channel_total,
    input wire logic [CHAN_W:0] i_output_channel_total,
    input wire logic [NUM_STREAMS*16-1:0] i_stream_error_counts,
    // pulse generator controls
    output logic [NUM_PULSES*8-1:0] o_pulse_channel_offset,
    output logic [NUM_PULSES*2-1:0] o_pulse_rate_select
);
    import tdm_regs_pkg::*;

    // ****************************************
    // local sizes
    // ****************************************
    // field widths follow the bit layout; the output ports stay fixed at 8 offset and 2 rate bits per pulse
    localparam int IDX_W = `ADDR_W;
    localparam int DATA_W = `HOST_DATA_W;
    localparam int COUNT_W = `STREAM_COUNT_W;
    localparam int OFFSET_W = `OFFSET_FIELD_MSB - `OFFSET_FIELD_LSB + 1;
    localparam int RATE_W = `RATE_FIELD_MSB - `RATE_FIELD_LSB + 1;

    // ****************************************
    // state
    // ****************************************
    // one packed record holds every flop of the block
    typedef struct packed {
        logic [NUM_PULSES-1:0][DATA_W-1:0] offset_ctrl;
        logic in_over;
        logic out_over;
        logic [NUM_STREAMS-1:0] err_flags;
        host_rsp_t rsp;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ****************************************
    // reset value
    // ****************************************
    localparam state_t STATE_RESET = '{
        offset_ctrl: {NUM_PULSES{`OFFSET_CTRL_RESET}},
        in_over: 1'h0,
        out_over: 1'h0,
        err_flags: {NUM_STREAMS{1'h0}},
        rsp: '{ack: 1'h0, rdata: `DATA_RESET}
    };

    // ****************************************
    // internal signals
    // ****************************************
    logic [CHAN_W:0] capacity;
    logic wr_take;
    logic rd_take;
    logic cap_hit;
    logic flags_hit;
    logic [NUM_PULSES-1:0] offset_hit;
    logic [NUM_STREAMS-1:0] count_nonzero;
    logic in_over_now;
    logic out_over_now;
    logic [DATA_W-1:0] offset_wdata;
    logic [DATA_W-1:0] offset_rword;
    logic [DATA_W-1:0] cap_rword;
    logic [DATA_W-1:0] flags_rword;
    logic [DATA_W-1:0] read_word;
    logic [NUM_PULSES-1:0][OFFSET_W-1:0] chan_offset;
    pulse_rate_t [NUM_PULSES-1:0] rate_sel;

    // ****************************************
    // request decode
    // ****************************************
    // requests are taken every cycle, back to back, with no busy state
    // a write wins over a read raised in the same cycle
    assign wr_take = i_host_req.wr;
    assign rd_take = i_host_req.rd & ~i_host_req.wr;
    assign cap_hit = (i_host_req.addr == `IDX_CAPACITY_ERROR);
    assign flags_hit = (i_host_req.addr == `IDX_ERROR_FLAGS_LOW);

    // one comparator per pulse register
    generate
        for (genvar p = 0; p < NUM_PULSES; p++) begin : g_offset_decode
            assign offset_hit[p] = (i_host_req.addr == `IDX_OFFSET_CTRL_BASE + IDX_W'(p));
        end
    endgenerate

    // ****************************************
    // offset write data
    // ****************************************
    // bits above the offset field are dropped so that they read back zero
    assign offset_wdata = i_host_req.wdata & `OFFSET_CTRL_MASK;

    // ****************************************
    // overcapacity detection
    // ****************************************
    // capacity is widened by one bit so a full-scale total still compares
    assign capacity = (CHAN_W+1)'(`SWITCH_CAPACITY);
    // a total equal to capacity is still legal; only a larger one flags
    // flags follow the totals, so lowering a total drops the flag with no write
    assign in_over_now = (i_input_channel_total > capacity); // [RULE_04] [RULE_05]
    assign out_over_now = (i_output_channel_total > capacity); // [RULE_03] [RULE_05]

    // ****************************************
    // stream error flags
    // ****************************************
    // the counters live outside this block; only their zero test is made here
    generate
        for (genvar s = 0; s < NUM_STREAMS; s++) begin : g_stream_flag
            assign count_nonzero[s] = |i_stream_error_counts[s*COUNT_W +: COUNT_W]; // [RULE_08]
        end
    endgenerate

    // ****************************************
    // read data
    // ****************************************
    // status is read from the registered copy so the word is settled
    // a read of a pulse index returns the stored word with masked bits zero
    always_comb begin
        offset_rword = `DATA_RESET;
        for (int p = 0; p < NUM_PULSES; p++) begin
            if (offset_hit[p]) begin
                offset_rword = state_reg.offset_ctrl[p];
            end
        end
    end

    always_comb begin
        cap_rword = `DATA_RESET;
        cap_rword[`CAP_INPUT_BIT] = state_reg.in_over;
        cap_rword[`CAP_OUTPUT_BIT] = state_reg.out_over;
    end

    // streams beyond the word width have no place in this register
    assign flags_rword = DATA_W'(state_reg.err_flags);

    // unmapped indices fall through to zero
    always_comb begin
        read_word = offset_rword;
        if (cap_hit) begin
            // upper bits stay zero
            read_word = cap_rword; // [RULE_07]
        end
        if (flags_hit) begin
            read_word = flags_rword;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    // ack answers every taken request, mapped or not, one cycle later
    // unmapped writes are acknowledged and change nothing
    always_comb begin
        state_next = state_reg;
        state_next.rsp.ack = 1'h0;
        state_next.in_over = in_over_now; // [RULE_09]
        state_next.out_over = out_over_now; // [RULE_09]
        state_next.err_flags = count_nonzero; // [RULE_09]
        if (wr_take) begin
            state_next.rsp.ack = 1'h1;
            for (int p = 0; p < NUM_PULSES; p++) begin
                if (offset_hit[p]) begin
                    state_next.offset_ctrl[p] = offset_wdata;
                end
            end
        end
        // read data holds between reads; writes leave it alone
        if (rd_take) begin
            state_next.rsp.ack = 1'h1;
            state_next.rsp.rdata = read_word;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    // reset clears offsets and flags; the flags refill on the first clock after release
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_host_rsp = state_reg.rsp;

    // pulse controls change only on reset or on a write to their own index
    generate
        for (genvar p = 0; p < NUM_PULSES; p++) begin : g_pulse_out
            // binary channel shift from frame boundary
            assign chan_offset[p] = state_reg.offset_ctrl[p][`OFFSET_FIELD_MSB:`OFFSET_FIELD_LSB]; // [RULE_01]
            assign o_pulse_channel_offset[p*OFFSET_W +: OFFSET_W] = chan_offset[p];
            // the rate code bounds the legal offset; keeping to it is left to the host
            assign rate_sel[p] = pulse_rate_t'(state_reg.offset_ctrl[p][`RATE_FIELD_MSB:`RATE_FIELD_LSB]);
            assign o_pulse_rate_select[p*RATE_W +: RATE_W] = rate_sel[p];
        end
    endgenerate
endmodule : tdm_switch_offset_and_error_regs

// File: tdm_regs_params.svh
`ifndef TDM_REGS_PARAMS_SVH
`define TDM_REGS_PARAMS_SVH

// register indices on the 16-bit parallel host bus
`define ADDR_W 14
`define HOST_DATA_W 16
`define STREAM_COUNT_W 16
`define IDX_OFFSET_CTRL_BASE 14'h0000
`define IDX_CAPACITY_ERROR 14'h0010
`define IDX_ERROR_FLAGS_LOW 14'h0011

// offset control field layout
`define OFFSET_FIELD_MSB 9
`define OFFSET_FIELD_LSB 2
`define RATE_FIELD_MSB 1
`define RATE_FIELD_LSB 0
`define OFFSET_CTRL_MASK 16'h03FF

// capacity error field layout
`define CAP_INPUT_BIT 0
`define CAP_OUTPUT_BIT 1

// reset values and capacity
`define OFFSET_CTRL_RESET 16'h0000
`define DATA_RESET 16'h0000
`define SWITCH_CAPACITY 14'h1000

`endif

// File: tdm_regs_pkg.sv
package tdm_regs_pkg;
    typedef struct packed {
        logic rd;
        logic wr;
        logic [13:0] addr;
        logic [15:0] wdata;
    } host_req_t;

    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } host_rsp_t;

    typedef enum logic [1:0] {
        RATE_2M = 2'h0,
        RATE_4M = 2'h1,
        RATE_8M = 2'h2,
        RATE_16M = 2'h3
    } pulse_rate_t;
endpackage : tdm_regs_pkg

// File: tdm_chk.sv
`timescale 1ns/1ns
module tdm_chk import tdm_regs_pkg::*; (input logic i_core_clk, i_rst, input host_req_t i_host_req,
    input host_rsp_t o_host_rsp, input logic [14:0] i_input_channel_total, i_output_channel_total,
    input logic [255:0] i_stream_error_counts, input logic [23:0] o_pulse_channel_offset,
    input logic [5:0] o_pulse_rate_select);
    wire [15:0] d = o_host_rsp.rdata;
    wire [15:0] wd = i_host_req.wdata;
    wire rc = i_host_req.rd && !i_host_req.wr && i_host_req.addr == 14'h0010;
    wire rf = i_host_req.rd && !i_host_req.wr && i_host_req.addr == 14'h0011;
    wire [1:0] ov = {i_output_channel_total > 15'h1000, i_input_channel_total > 15'h1000};
    logic [15:0] nz;
    always_comb for (int s = 0; s < 16; s++) nz[s] = |i_stream_error_counts[s*16+:16];
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_off; i_host_req.wr && i_host_req.addr == 14'h0000 |=> o_pulse_channel_offset[7:0] == $past(wd[9:2]); endproperty
    a_off: assert property (p_off) else $error("offset");
    property p_rate; i_host_req.wr && i_host_req.addr == 14'h0002 |=> o_pulse_rate_select[5:4] == $past(wd[1:0]); endproperty
    a_rate: assert property (p_rate) else $error("rate");
    property p_out; rc && $stable(ov) |=> d[1] == $past(ov[1]); endproperty
    a_out: assert property (p_out) else $error("out flag");
    property p_in; rc && $stable(ov) |=> d[0] == $past(ov[0]); endproperty
    a_in: assert property (p_in) else $error("in flag");
    property p_clr; rc && ov == 2'h0 && $stable(ov) |=> d[1:0] == 2'h0; endproperty
    a_clr: assert property (p_clr) else $error("clear");
    property p_hi; rc |=> d[15:2] == 14'h0000; endproperty
    a_hi: assert property (p_hi) else $error("upper");
    property p_ber; rf && $stable(nz) |=> d == $past(nz); endproperty
    a_ber: assert property (p_ber) else $error("flags");
endmodule : tdm_chk
bind tdm_switch_offset_and_error_regs tdm_chk chk (.*);

// File: tdm_host.sv
`timescale 1ns/1ns
module tdm_host import tdm_regs_pkg::*; (input logic i_core_clk, input host_rsp_t i_rsp, output host_req_t o_req);
    initial o_req = '0;
    // offsets stay legal for the rate; totals go back under capacity after a flag
    task automatic access(input logic w, input logic [13:0] a, input logic [15:0] d, output logic [16:0] q);
        o_req <= '{~w, w, a, d};
        repeat (2) @(posedge i_core_clk);
        q = {i_rsp.ack, i_rsp.rdata};
        o_req <= '{1'h0, 1'h0, ~a, ~d};
        @(posedge i_core_clk);
    endtask : access
endmodule : tdm_host

// File: test_tdm_switch_offset_and_error_regs.sv
`timescale 1ns/1ns
module test_tdm_switch_offset_and_error_regs;
    import tdm_regs_pkg::*;
    logic i_core_clk = 1'h0, i_rst = 1'h1;
    logic [29:0] tot = 30'h0;
    logic [255:0] cnt = 256'h0;
    logic [16:0] q;
    wire [29:0] po;
    host_req_t req;
    host_rsp_t rsp;
    int fail_count = 0, checks = 0;
    always #20 i_core_clk = ~i_core_clk;
    tdm_host host (.i_core_clk(i_core_clk), .i_rsp(rsp), .o_req(req));
    tdm_switch_offset_and_error_regs dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_host_req(req), .o_host_rsp(rsp),
        .i_input_channel_total(tot[29:15]), .i_output_channel_total(tot[14:0]), .i_stream_error_counts(cnt),
        .o_pulse_channel_offset(po[29:6]), .o_pulse_rate_select(po[5:0]));
    task automatic rw(input logic w, input logic [13:0] a, input logic [16:0] e);
        host.access(w, a, 16'h0000, q);
        checks++;
        if (q !== e) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, q, e);
        end
    endtask : rw
    task automatic offs;
        for (int p = 0; p < 3; p++) begin
            host.access(1'h1, 14'(p), 16'hFC25 + 16'(p), q);
            checks++;
            if (q[16] !== 1'h1 || po[p*8+6+:8] !== 8'h09 || po[p*2+:2] !== 2'(p + 1)) begin
                fail_count++;
                $display("BAD %0t pulse %0d ack %h offset %h rate %h", $time, p, q[16], po[p*8+6+:8], po[p*2+:2]);
            end
            rw(1'h0, 14'(p), 17'h10025 + 17'(p));
        end
        checks++;
        if (po !== {24'h090909, 6'h39}) begin
            fail_count++;
            $display("BAD %0t pulse controls %h", $time, po);
        end
    endtask : offs
    task automatic reset_mid_run;
        i_rst <= 1'h1;
        repeat (2) @(posedge i_core_clk);
        checks++;
        if (po !== 30'h0 || rsp !== '0) begin
            fail_count++;
            $display("BAD %0t outputs not cleared by reset", $time);
        end
        i_rst <= 1'h0;
        @(posedge i_core_clk);
        rw(1'h0, 14'h0000, 17'h10000);
    endtask : reset_mid_run
    task automatic cap;
        logic [29:0] tab [3] = '{{15'h1001, 15'h1000}, {15'h1000, 15'h1001}, 30'h0};
        foreach (tab[i]) begin
            tot <= tab[i];
            repeat (3) @(posedge i_core_clk);
            rw(1'h0, 14'h0010, {15'h4000, tab[i][14:0] > 15'h1000, tab[i][29:15] > 15'h1000});
        end
    endtask : cap
    task automatic ber;
        cnt <= {16'h0001, 224'h0, 16'h0100};
        repeat (3) @(posedge i_core_clk);
        rw(1'h0, 14'h0011, 17'h18001);
        cnt <= 256'h20 << 112;
        repeat (3) @(posedge i_core_clk);
        rw(1'h0, 14'h0011, 17'h10080);
        rw(1'h0, 14'h3FFF, 17'h10000);
    endtask : ber
    task automatic conclude;
        if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    initial begin
        repeat (12) @(posedge i_core_clk);
        i_rst <= 1'h0;
        @(posedge i_core_clk);
        offs();
        reset_mid_run();
        cap();
        ber();
        conclude();
    end
    initial begin
        #40000;
        fail_count++;
        $display("BAD %0t timeout", $time);
        conclude();
    end
endmodule : test_tdm_switch_offset_and_error_regs
